// ===== core/cpu_bus_pkg.sv
// constants and types shared by both ends of the processor local bus link
// assumes a single 40 MHz clock, no software-visible registers
package cpu_bus_pkg;
    localparam int unsigned CLK_PERIOD_NS = 25;
    // legacy processor mode strap level on the coprocessor busy pin
    localparam logic LEGACY_MODE_LEVEL = 1'b1;
    // index of the last word of a line-fill burst (four words, 0 to 3)
    localparam logic [1:0] BURST_LAST_WORD = 2'h3;
    // external ready sync depth and tag write pulse width in cycles
    localparam int unsigned READY_SYNC_STAGES = 2;
    localparam logic [1:0] TAG_WE_CYCLES = 2'h1;
    // address window that the cache serves as cacheable (top bit of upper address)
    localparam logic CACHEABLE_TOP = 1'b0;
    // reset values
    localparam logic [3:0] BE_RESET = 4'hF;
    localparam logic [8:0] ADDR_MID_RESET = 9'h000;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_T1 = 5'b00010,
        ST_T2 = 5'b00100,
        ST_BURST = 5'b01000,
        ST_DMA = 5'b10000
    } bus_state_t;
endpackage

// ===== core/cpu_bus_if.sv
// interface joining the processor end and the system controller end
// assumes the testbench resolves shared pins from the output enables
`timescale 1ns/10ps
interface cpu_bus_if;
    // cycle status pins, two-way
    logic cycle_start_strobe_n_p, cycle_start_strobe_n_c, cycle_start_strobe_n_oe_c;
    logic mem_io_p, mem_io_c, mem_io_oe_c;
    logic write_read_p, write_read_c, write_read_oe_c;
    logic [3:0] byte_lane_enables_n_p, byte_lane_enables_n_c;
    logic byte_lane_enables_oe_c;
    logic [8:0] cpu_addr_mid_bits_p, cpu_addr_mid_bits_c;
    logic cpu_addr_mid_oe_c;
    // address bits 5:2 from processor, parity from device afterwards
    logic [3:0] cpu_addr_low_bits_p, dram_parity_bits_c;
    logic dram_parity_oe_c;
    logic cpu_addr3_p;
    logic data_code_p;
    logic burst_final_n_p;
    // ready, two-way: device drives unless a local device owns it
    logic ready_n_c, ready_oe_c, ready_n_local;
    logic burst_ready_n_c;
    logic cacheable_n_c;
    logic local_device_claim_n;
    logic hold_ack_p;
    logic coproc_busy_n;

    modport device (
        input cycle_start_strobe_n_p, mem_io_p, write_read_p, byte_lane_enables_n_p,
        input cpu_addr_mid_bits_p, cpu_addr_low_bits_p, cpu_addr3_p, data_code_p,
        input burst_final_n_p, ready_n_local, local_device_claim_n, hold_ack_p,
        input coproc_busy_n,
        output cycle_start_strobe_n_c, cycle_start_strobe_n_oe_c, mem_io_c, mem_io_oe_c,
        output write_read_c, write_read_oe_c, byte_lane_enables_n_c, byte_lane_enables_oe_c,
        output cpu_addr_mid_bits_c, cpu_addr_mid_oe_c, dram_parity_bits_c, dram_parity_oe_c,
        output ready_n_c, ready_oe_c, burst_ready_n_c, cacheable_n_c
    );
    modport host (
        output cycle_start_strobe_n_p, mem_io_p, write_read_p, byte_lane_enables_n_p,
        output cpu_addr_mid_bits_p, cpu_addr_low_bits_p, cpu_addr3_p, data_code_p,
        output burst_final_n_p, hold_ack_p,
        input ready_n_c, ready_oe_c, burst_ready_n_c, cacheable_n_c, cycle_start_strobe_n_c,
        input cycle_start_strobe_n_oe_c
    );
endinterface

// ===== core/cpu_bus_host.sv
// processor end: issues single and burst cycles, acknowledges hold
// assumes device answers ready or burst ready on the same clock
`timescale 1ns/10ps
module cpu_bus_host (
    input wire logic clk_sys,
    input wire logic rst_n,
    cpu_bus_if.host bus,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_mem,
    input wire logic req_data,
    input wire logic req_burst,
    input wire logic [3:0] req_be_n,
    input wire logic [14:0] req_addr,
    input wire logic hold_req,
    output logic busy,
    output logic done,
    output logic hold_granted
);
    import cpu_bus_pkg::*;

    typedef struct packed {
        logic active;
        logic done;
        logic ads_n;
        logic we;
        logic mio;
        logic dc;
        logic burst;
        logic [1:0] cnt;
        logic [3:0] be_n;
        logic [14:0] addr;
        logic hlda;
    } host_t;
    host_t q, d;

    // ****************************************
    // cycle issue
    // ****************************************
    // processor strobes the start of each new cycle
    always_comb begin
        d = q;
        d.ads_n = 1'b1;
        d.done = 1'b0;
        d.hlda = hold_req & ~q.active;
        if (!q.active && req_valid && !hold_req) begin
            d.active = 1'b1;
            d.ads_n = 1'b0;
            d.we = req_write;
            d.mio = req_mem;
            d.dc = req_data;
            d.burst = req_burst & ~req_write;
            d.cnt = 2'h0;
            d.be_n = req_be_n;
            d.addr = req_addr;
        end else if (q.active) begin
            if (!bus.burst_ready_n_c) begin
                d.cnt = q.cnt + 2'h1;
                // burst ends when final flag is shown low
                if (!q.burst || q.cnt == BURST_LAST_WORD) begin
                    d.active = 1'b0;
                    d.done = 1'b1;
                end
            end else if (!bus.ready_n_c) begin
                d.active = 1'b0;
                d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
            q.ads_n <= 1'b1;
            q.be_n <= BE_RESET;
        end else begin
            q <= d;
        end
    end

    assign bus.cycle_start_strobe_n_p = q.ads_n;
    assign bus.write_read_p = q.we;
    assign bus.mem_io_p = q.mio;
    assign bus.data_code_p = q.dc;
    assign bus.byte_lane_enables_n_p = q.be_n;
    assign bus.cpu_addr_mid_bits_p = q.addr[14:6];
    assign bus.cpu_addr_low_bits_p = q.addr[3:0];
    assign bus.cpu_addr3_p = q.addr[1];
    // final flag low on the last word of a burst, always low for singles
    assign bus.burst_final_n_p = ~(~q.burst | (q.cnt == BURST_LAST_WORD));
    assign bus.hold_ack_p = q.hlda;
    assign busy = q.active;
    assign done = q.done;
    assign hold_granted = q.hlda;
endmodule

// ===== core/cpu_bus_device.sv
// system controller end: cycle decode, ready generation, cache sram control
// assumes processor drives status while hold ack is low; one 40 MHz clock
`timescale 1ns/10ps
// Summary of operation
// - processor strobes cycle start; device drives in DMA
// - byte enables input; decoded from SA, SBHE in DMA
// - burst ends on final flag low at T2
// - burst ready per word; legacy mode request out
// - latch addr 5:2, then drive parity
// - mid address from latched peripheral byte in DMA
// - data/control status decoded
// - cacheable low idle, high after T1, low if cacheable
// - sample local device claim at first T2
// - memory/io status, device drives in DMA
// - drive ready, release during local device cycle
// - synchronise external ready before passing on
// - write/read status, device drives in DMA
// - even bank addr3 floats, then follows, toggles
// - odd bank addr3 same; single bank acts addr2
// - even bank enable when addr2 low, toggles
// - odd bank enable is inverse of even on cache reads and in T2 of dirty writebacks; both high otherwise
// - addr3 select active in T1 and first T2
// - write enable 1 even bank, 0 odd
// - tag write pulse; tag shares dram address
// - coprocessor busy high selects legacy mode
// - one master clock drives everything
module cpu_bus_device (
    input wire logic clk_sys,
    input wire logic rst_n,
    cpu_bus_if.device bus,
    input wire logic external_ready_in_n,
    input wire logic parity_check_en,
    input wire logic single_bank,
    input wire logic cache_hit,
    input wire logic dirty_writeback,
    input wire logic tag_update,
    input wire logic [7:0] tag_value,
    input wire logic [3:0] parity_out,
    input wire logic dma_16bit,
    input wire logic dma_strobe,
    input wire logic [7:0] peripheral_data_byte,
    input wire logic [1:0] sys_addr_low,
    input wire logic sys_byte_high_n,
    input wire logic dma_write,
    input wire logic dma_mem,
    input wire logic dma_start,
    input wire logic proc_request_in,
    output logic proc_request_out,
    output logic data_cycle,
    output logic local_cycle,
    output logic [3:0] latched_addr_low,
    output logic even_bank_addr3,
    output logic even_bank_addr3_oe,
    output logic odd_bank_addr3,
    output logic odd_bank_addr3_oe,
    output logic even_bank_output_en_n,
    output logic odd_bank_output_en_n,
    output logic cache_addr3_select_n,
    output logic [1:0] cache_bank_write_en_n,
    output logic tag_write_en_n,
    output logic [7:0] dram_row_col_addr
);
    import cpu_bus_pkg::*;

    typedef struct packed {
        bus_state_t st;
        logic [1:0] rdy_sync;
        logic legacy;
        logic dma;
        logic ads_n;
        logic ads_oe;
        logic mio;
        logic we;
        logic dc;
        logic [3:0] be_n;
        logic [7:0] xd;
        logic xd16;
        logic [3:0] alow;
        logic mp_oe;
        logic local_q;
        logic rdy_n;
        logic rdy_oe;
        logic burst_ready_n_n;
        logic ken_n;
        logic first_t2;
        logic a3;
        logic a3_oe;
        logic oe_even_n;
        logic oe_odd_n;
        logic a3s_n;
        logic [1:0] cawe_n;
        logic tag_write_en_n_n;
        logic [1:0] tag_cnt;
        logic [1:0] wcnt;
        logic preq;
    } dev_t;
    dev_t q, d;
    logic rdy_ext_n;

    // ****************************************
    // state update
    // ****************************************
    assign rdy_ext_n = q.rdy_sync[1]; // second stage only

    always_comb begin
        d = q;
        d.rdy_sync = {q.rdy_sync[0], external_ready_in_n};
        d.legacy = (bus.coproc_busy_n == LEGACY_MODE_LEVEL);
        d.preq = proc_request_in;
        d.dma = bus.hold_ack_p;
        d.ads_n = 1'b1;
        d.rdy_n = 1'b1;
        d.burst_ready_n_n = 1'b1;
        d.cawe_n = 2'h3;
        d.ads_oe = bus.hold_ack_p;
        if (q.tag_cnt != 2'h0) begin
            d.tag_cnt = q.tag_cnt - 2'h1;
        end else begin
            d.tag_write_en_n_n = 1'b1;
        end
        // dma byte latch; 16-bit uses bits 16:9, 8-bit bits 15:8
        if (dma_strobe) begin
            d.xd = peripheral_data_byte;
            d.xd16 = dma_16bit;
        end
        unique case (q.st)
            ST_IDLE: begin
                d.ken_n = 1'b0; // low at rest
                d.a3_oe = 1'b0;
                d.a3s_n = 1'b1;
                d.mp_oe = 1'b0;
                d.oe_even_n = 1'b1;
                d.oe_odd_n = 1'b1;
                if (bus.hold_ack_p) begin
                    d.st = ST_DMA;
                end else if (!bus.cycle_start_strobe_n_p) begin
                    d.st = ST_T1;
                    d.mio = bus.mem_io_p;
                    d.we = bus.write_read_p;
                    d.dc = bus.data_code_p;
                    d.be_n = bus.byte_lane_enables_n_p;
                    d.alow = bus.cpu_addr_low_bits_p;
                    d.a3 = bus.cpu_addr3_p;
                    d.a3s_n = 1'b0;
                    d.first_t2 = 1'b1;
                    d.wcnt = 2'h0;
                end
            end
            ST_T1: begin
                d.ken_n = 1'b1; // raised at end of T1
                d.mp_oe = parity_check_en;
                d.st = ST_T2;
            end
            ST_T2: begin
                d.first_t2 = 1'b0;
                d.a3s_n = 1'b1;
                d.a3_oe = 1'b1; // drive after first half of T2
                if (q.first_t2) begin
                    d.local_q = ~bus.local_device_claim_n;
                    d.rdy_oe = bus.local_device_claim_n;
                    d.ken_n = ~(q.mio && cache_hit && bus.cpu_addr_mid_bits_p[8] == CACHEABLE_TOP);
                end
                // cache read: bank enable from addr bit 2
                if (!q.we && cache_hit) begin
                    d.oe_even_n = q.alow[0];
                    d.oe_odd_n = ~q.alow[0];
                end
                if (q.we && cache_hit) begin
                    d.cawe_n = q.alow[0] ? 2'h2 : 2'h1;
                end
                if (q.local_q && !q.first_t2) begin
                    if (!bus.ready_n_local) begin
                        d.st = ST_IDLE;
                    end
                end else if (!q.first_t2 && !q.ken_n && !q.legacy && !q.we
                    && cache_hit) begin
                    d.st = ST_BURST;
                    d.burst_ready_n_n = 1'b0;
                end else if (!q.first_t2 && (!rdy_ext_n || cache_hit)) begin
                    d.rdy_n = 1'b0;
                    d.st = ST_IDLE;
                end
                // once per cycle; counter holds the pulse for TAG_WE_CYCLES
                if (q.first_t2 && tag_update && !cache_hit) begin
                    d.tag_write_en_n_n = 1'b0;
                    d.tag_cnt = TAG_WE_CYCLES - 2'h1;
                end
            end
            ST_BURST: begin
                // toggle bank address and enables per word
                d.a3 = ~q.a3;
                d.oe_even_n = ~q.oe_even_n;
                d.oe_odd_n = q.oe_even_n;
                d.wcnt = q.wcnt + 2'h1;
                // final flag checked each T2 with burst ready
                if (!bus.burst_final_n_p || q.wcnt == BURST_LAST_WORD) begin
                    d.st = ST_IDLE;
                end else begin
                    d.burst_ready_n_n = 1'b0;
                end
            end
            ST_DMA: begin
                d.ads_oe = 1'b1;
                d.mio = dma_mem;
                d.we = dma_write;
                // byte enables from system address low bits
                d.be_n = 4'hF;
                d.be_n[sys_addr_low] = 1'b0;
                if (!sys_byte_high_n) begin
                    d.be_n[{sys_addr_low[1], 1'b1}] = 1'b0;
                end
                if (dma_start) begin
                    d.ads_n = 1'b0;
                end
                if (!bus.hold_ack_p) begin
                    d.st = ST_IDLE;
                    d.ads_oe = 1'b0;
                end
            end
            default: d.st = ST_IDLE;
        endcase
        if (dirty_writeback && q.st == ST_T2) begin
            d.a3 = ~q.a3;
            d.oe_even_n = ~q.oe_even_n;
            d.oe_odd_n = q.oe_even_n;
        end
    end

    // ****************************************
    // registers, one clock
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.rdy_sync <= 2'h3;
            q.ads_n <= 1'b1;
            q.be_n <= BE_RESET;
            q.rdy_n <= 1'b1;
            q.rdy_oe <= 1'b1;
            q.burst_ready_n_n <= 1'b1;
            q.oe_even_n <= 1'b1;
            q.oe_odd_n <= 1'b1;
            q.a3s_n <= 1'b1;
            q.cawe_n <= 2'h3;
            q.tag_write_en_n_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // pin mapping
    // ****************************************
    assign bus.cycle_start_strobe_n_c = q.ads_n;
    assign bus.cycle_start_strobe_n_oe_c = q.ads_oe;
    assign bus.mem_io_c = q.mio;
    assign bus.mem_io_oe_c = q.dma;
    assign bus.write_read_c = q.we;
    assign bus.write_read_oe_c = q.dma;
    assign bus.byte_lane_enables_n_c = q.be_n;
    assign bus.byte_lane_enables_oe_c = q.dma;
    // 8-bit dma shifts the byte down one place
    assign bus.cpu_addr_mid_bits_c = q.xd16 ? {q.xd, 1'b0} : {1'b0, q.xd};
    assign bus.cpu_addr_mid_oe_c = q.dma;
    assign bus.dram_parity_bits_c = parity_out;
    assign bus.dram_parity_oe_c = q.mp_oe;
    assign bus.ready_n_c = q.rdy_n;
    assign bus.ready_oe_c = q.rdy_oe;
    // legacy mode: pin carries request output instead
    assign bus.burst_ready_n_c = q.legacy ? q.preq : q.burst_ready_n_n;
    assign bus.cacheable_n_c = q.ken_n; // same cacheable status in legacy mode; no separate error output
    assign proc_request_out = q.preq;
    assign data_cycle = q.dc;
    assign local_cycle = q.local_q;
    assign latched_addr_low = q.alow;
    assign even_bank_addr3 = q.a3;
    assign even_bank_addr3_oe = q.a3_oe;
    // single bank: odd pin carries even bank addr2
    assign odd_bank_addr3 = single_bank ? q.alow[0] : q.a3;
    assign odd_bank_addr3_oe = q.a3_oe;
    assign even_bank_output_en_n = q.oe_even_n;
    assign odd_bank_output_en_n = q.oe_odd_n;
    assign cache_addr3_select_n = q.a3s_n;
    assign cache_bank_write_en_n = q.cawe_n;
    assign tag_write_en_n = q.tag_write_en_n_n;
    assign dram_row_col_addr = tag_value; // shared tag lines
endmodule

// ===== testbench/cpu_bus_cycle_properties.sv
// concurrent checks on the processor bus link between host and controller ends
// assumes the interface signals arrive directly, one clock, sync active-low reset
`timescale 1ns/10ps
module cpu_bus_cycle_properties (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cycle_start_strobe_n_p,
    input wire logic cycle_start_strobe_n_oe_c,
    input wire logic hold_ack_p,
    input wire logic coproc_busy_n,
    input wire logic burst_final_n_p,
    input wire logic ready_n_c,
    input wire logic ready_oe_c,
    input wire logic burst_ready_n_c,
    input wire logic cacheable_n_c,
    input wire logic byte_lane_enables_oe_c,
    input wire logic mem_io_oe_c,
    input wire logic write_read_oe_c
);
    // ****************************************
    // clocking and shared sequences
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // processor cycle taken in burst-capable mode; legacy reuses some pins
    sequence taken_s;
        $fell(cycle_start_strobe_n_p) && !hold_ack_p && !coproc_busy_n;
    endsequence

    // ****************************************
    // assertions
    // ****************************************
    a_ready_not_early: assert property (taken_s |=> ready_n_c [*3])
        else $error("ready came before the fourth cycle");
    a_ready_on_time: assert property (taken_s
        |-> ##4 (!ready_n_c || !burst_ready_n_c))
        else $error("no ready four cycles after cycle start");
    a_ready_one_cycle: assert property ((!ready_n_c && ready_oe_c) |=> ready_n_c)
        else $error("ready held longer than one cycle");
    a_cacheable_rise: assert property (taken_s |-> ##[1:2] cacheable_n_c)
        else $error("cacheable status not raised after first state");
    a_burst_final_end: assert property (
        (!burst_ready_n_c && !burst_final_n_p && !coproc_busy_n) |=> burst_ready_n_c)
        else $error("burst continued after final word");
    a_status_pins_in: assert property (
        (!hold_ack_p && !$past(hold_ack_p))
        |-> !byte_lane_enables_oe_c && !mem_io_oe_c && !write_read_oe_c)
        else $error("status pins driven outside hold");
    a_strobe_pin_in: assert property ((!hold_ack_p && !$past(hold_ack_p))
        |-> !cycle_start_strobe_n_oe_c)
        else $error("cycle start strobe driven outside hold");
    a_dma_lanes_driven: assert property ((hold_ack_p && $past(hold_ack_p))
        |-> byte_lane_enables_oe_c)
        else $error("byte lanes not driven during hold");
    a_hold_no_burst: assert property (
        (hold_ack_p && $past(hold_ack_p) && !coproc_busy_n) |-> burst_ready_n_c)
        else $error("burst ready during hold");

    // ****************************************
    // coverage of main scenarios
    // ****************************************
    c_cycle: cover property (taken_s);
    c_burst_end: cover property (!burst_ready_n_c && !burst_final_n_p);
    c_hold: cover property ($rose(hold_ack_p));
endmodule

// ===== testbench/cpu_bus_cycle_and_cache_control_tb.sv
// self-checking bench: host and controller ends joined by the bus interface
// assumes a 40 MHz clock and a synchronous active-low reset on both ends
`timescale 1ns/10ps
module cpu_bus_cycle_and_cache_control_tb;
    import cpu_bus_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid, req_write, req_mem, req_data, req_burst, hold_req, busy, done;
    logic [3:0] req_be_n, parity_out, latched_addr_low, snap_lat;
    logic [14:0] req_addr;
    logic hold_granted, external_ready_in_n, parity_check_en, single_bank, cache_hit;
    logic dirty_writeback, tag_update, dma_16bit, dma_strobe, sys_byte_high_n, dma_write;
    logic dma_mem, dma_start, proc_request_in, proc_request_out, data_cycle, local_cycle;
    logic [7:0] tag_value, peripheral_data_byte, dram_row_col_addr, tag_got, snap;
    logic [1:0] sys_addr_low, cache_bank_write_en_n, we_seen;
    logic even_bank_addr3, even_bank_addr3_oe, odd_bank_addr3, odd_bank_addr3_oe;
    logic even_bank_output_en_n, odd_bank_output_en_n, cache_addr3_select_n;
    logic tag_write_en_n, in_op, got_ans, sel_seen, a3oe_t1;
    logic [14:0] adr;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int age = 0;
    int n, tag_cnt, burst_ready_n_cnt;

    cpu_bus_if bus ();
    cpu_bus_host i_cpu_bus_host (.*);
    cpu_bus_device i_cpu_bus_device (.*);
    cpu_bus_cycle_properties i_cpu_bus_cycle_properties (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .cycle_start_strobe_n_p(bus.cycle_start_strobe_n_p),
        .cycle_start_strobe_n_oe_c(bus.cycle_start_strobe_n_oe_c),
        .hold_ack_p(bus.hold_ack_p), .coproc_busy_n(bus.coproc_busy_n),
        .burst_final_n_p(bus.burst_final_n_p), .ready_n_c(bus.ready_n_c),
        .ready_oe_c(bus.ready_oe_c), .burst_ready_n_c(bus.burst_ready_n_c),
        .cacheable_n_c(bus.cacheable_n_c), .byte_lane_enables_oe_c(bus.byte_lane_enables_oe_c),
        .mem_io_oe_c(bus.mem_io_oe_c), .write_read_oe_c(bus.write_read_oe_c));

    // ****************************************
    // clock, timeout and capture
    // ****************************************
    always #12.5 clk_sys = ~clk_sys;

    // a run far past a few hundred cycles means a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            give_verdict();
        end
    end

    // blocking reads here see pre-edge values, as the design samples them
    always @(posedge clk_sys) begin
        age = bus.cycle_start_strobe_n_p ? age + 1 : 0;
        if (age == 1) a3oe_t1 = even_bank_addr3_oe;
        if (in_op) begin
            we_seen = we_seen | ~cache_bank_write_en_n;
            burst_ready_n_cnt += int'(!bus.burst_ready_n_c);
            if (!tag_write_en_n) begin
                tag_cnt++;
                tag_got = dram_row_col_addr;
            end
            if (!cache_addr3_select_n) sel_seen = 1'b1;
            if (!got_ans && (!bus.ready_n_c || !bus.burst_ready_n_c)) begin
                got_ans = 1'b1;
                snap = {bus.dram_parity_oe_c, bus.cacheable_n_c, even_bank_output_en_n,
                    odd_bank_output_en_n, even_bank_addr3, even_bank_addr3_oe,
                    odd_bank_addr3, data_cycle};
                snap_lat = latched_addr_low;
            end
        end
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic check_vec(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // one processor cycle; request held until the host reports busy
    task automatic cyc(input logic wr, input logic bst, input logic [14:0] a);
        {we_seen, tag_cnt, burst_ready_n_cnt, sel_seen, got_ans} = '0;
        {req_write, req_burst, req_addr, req_data} = {wr, bst, a, a[2]};
        parity_out = ~a[3:0];
        req_valid = 1'b1;
        in_op = 1'b1;
        n = 0;
        @(posedge clk_sys);
        while (busy !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        req_valid = 1'b0;
        while (done !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        check_bit(n < 50, 1'b1);
        @(negedge clk_sys);
        in_op = 1'b0;
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {req_valid, req_write, req_data, req_burst, hold_req, in_op, tag_update} = '0;
        {req_mem, parity_check_en, sys_byte_high_n, cache_hit} = 4'hF;
        {single_bank, dirty_writeback, dma_16bit, dma_strobe, dma_write} = '0;
        {dma_mem, dma_start, proc_request_in, external_ready_in_n} = '0;
        {req_be_n, req_addr, tag_value, peripheral_data_byte, parity_out, sys_addr_low} = '0;
        bus.ready_n_local = 1'b1;
        bus.local_device_claim_n = 1'b1;
        bus.coproc_busy_n = 1'b0;
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        // cache reads over address bits, cacheability and bank count
        for (int i = 0; i < 16; i++) begin
            single_bank = i[2] ^ i[1];
            adr = {i[3] ^ i[0], 10'h2A5, i[3:0]};
            cyc(1'b0, 1'b0, adr);
            check_vec(snap[7:4], {parity_check_en, adr[14] != CACHEABLE_TOP,
                adr[0], ~adr[0]});
            check_vec(snap[3:0], {adr[1], 1'b1, single_bank ? adr[0] : adr[1],
                adr[2]});
            check_vec(snap_lat, adr[3:0]);
            check_bit(sel_seen, 1'b1);
            check_bit(a3oe_t1, 1'b0);
        end
        // a write hit to each bank, each followed by a write miss that updates the tag
        single_bank = 1'b0;
        for (int i = 0; i < 2; i++) begin
            tag_value = 8'h3C ^ i[7:0];
            cyc(1'b1, 1'b0, {14'h0000, i[0]});
            check_vec(we_seen, i[0] ? 2'h1 : 2'h2);
            {cache_hit, tag_update} = 2'h1;
            cyc(1'b1, 1'b0, {14'h0000, i[0]});
            check_vec(we_seen, 2'h0);
            check_vec(tag_cnt[15:0], TAG_WE_CYCLES);
            check_vec(tag_got, tag_value);
            {cache_hit, tag_update} = 2'h2;
        end
        // line fill: one burst ready per word, then stop on the final flag
        cyc(1'b0, 1'b1, 15'h0010);
        check_vec(burst_ready_n_cnt[15:0], BURST_LAST_WORD + 1);
        // legacy mode carries the coprocessor request through
        bus.coproc_busy_n = 1'b1;
        for (int k = 1; k >= 0; k--) begin
            proc_request_in = k[0];
            repeat (4) @(negedge clk_sys);
            check_bit(proc_request_out, k[0]);
            check_bit(bus.burst_ready_n_c, k[0]);
        end
        bus.coproc_busy_n = 1'b0;
        // hold: device drives lanes, mid address and a local strobe
        hold_req = 1'b1;
        n = 0;
        while (hold_granted !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        repeat (2) @(negedge clk_sys);
        for (int j = 0; j < 8; j++) begin
            {sys_byte_high_n, sys_addr_low} = j[2:0];
            repeat (3) @(negedge clk_sys);
            check_vec(bus.byte_lane_enables_n_c, 4'(~((4'h1 << j[1:0])
                | ((!j[2] && !j[0]) ? (4'h2 << j[1:0]) : 4'h0))));
        end
        for (int k = 0; k < 2; k++) begin
            {dma_16bit, dma_mem, dma_write} = {k[0], k[0], ~k[0]};
            peripheral_data_byte = 8'h5A ^ k[7:0];
            dma_strobe = 1'b1;
            @(negedge clk_sys);
            dma_strobe = 1'b0;
            repeat (3) @(negedge clk_sys);
            check_vec(bus.cpu_addr_mid_bits_c, k[0] ? {peripheral_data_byte, 1'b0}
                : {1'b0, peripheral_data_byte});
            dma_start = 1'b1;
            @(negedge clk_sys);
            dma_start = 1'b0;
            n = 0;
            while (!(bus.cycle_start_strobe_n_oe_c === 1'b1 && bus.cycle_start_strobe_n_c === 1'b0)
                && n < 20) begin
                @(posedge clk_sys);
                n++;
            end
            check_bit(n < 20, 1'b1);
            check_vec({bus.mem_io_c, bus.write_read_c}, {k[0], ~k[0]});
            @(negedge clk_sys);
        end
        hold_req = 1'b0;
        repeat (10) @(negedge clk_sys);
        check_bit(hold_granted, 1'b0);
        give_verdict();
    end
endmodule
